// File: bench/shd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module shd_host_model (
   // clock
   input wire logic core_clk,
   // bus outputs
   output logic [9:0] host_addr,
   output logic host_wr,
   output logic host_rd,
   output logic [7:0] host_wdata,
   // answer
   input wire logic [7:0] host_rdata_q
);
   logic [9:0] base = 10'h200;
   int idle = 0;
   initial begin
      host_addr = 10'h000;
      host_wr = 1'b0;
      host_rd = 1'b0;
      host_wdata = 8'h00;
   end
   // low byte before high byte is the caller's order
   task automatic wr(input logic [3:0] ofs, input logic [7:0] d);
      repeat (idle) @(negedge core_clk);
      @(negedge core_clk);
      host_addr = {base[9:4], ofs};
      host_wdata = d;
      host_wr = 1'b1;
      @(negedge core_clk);
      host_wr = 1'b0;
      host_wdata = ~d;
   endtask
   task automatic rd(input logic [3:0] ofs, output logic [7:0] d);
      repeat (idle) @(negedge core_clk);
      @(negedge core_clk);
      host_addr = {base[9:4], ofs};
      host_rd = 1'b1;
      @(negedge core_clk);
      host_rd = 1'b0;
      @(negedge core_clk);
      d = host_rdata_q;
   endtask
endmodule // shd_host_model
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import shd_pkg::*;
   logic core_clk = 1'b0, reset = 1'b1;
   logic [9:0] host_addr, codec_io_base = 10'h200;
   logic host_wr, host_rd, conv_rdy = 1'b0, pdn = 1'b0, legacy = 1'b0;
   logic [7:0] host_wdata, rdata, hrd, ev = 8'h00, gr = 8'h5a;
   logic [3:0] irq_ch = 4'h5;
   logic [2:0] pbd = 3'h1, capd = 3'h4;
   logic pk_v = 1'b0, cv = 1'b0, tick = 1'b0, rok, sgl, irq_sh, cap_rdy, dac_v, cm, hit;
   logic [7:0] pbs, cps;
   logic [1:0] pl = 2'h0, pr = 2'h0;
   logic [31:0] cd = 32'h0, dac, last_dac;
   logic [5:0] cm_i;
   logic [15:0] cm_d, axis = 16'hbeef;
   int n_errors = 0, comparisons = 0, n_cm = 0, n_dac = 0, n_hit = 0, n_rd = 0;
   logic [3:0] irq_list [6] = '{4'h5, 4'h7, 4'h9, 4'hb, 4'hc, 4'hf};
   always #2.5 core_clk = ~core_clk;
   shd_host_model host_u (.core_clk(core_clk), .host_addr(host_addr), .host_wr(host_wr),
      .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata_q(hrd));
   shd_direct_regs #(.FIFO_DEPTH(16)) dut_u (.core_clk(core_clk), .reset(reset),
      .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
      .host_rdata_q(hrd), .host_hit_q(hit), .codec_io_base(codec_io_base), .irq_channel(irq_ch),
      .pb_dma_sel(pbd), .cap_dma_sel(capd), .resource_ok_q(rok), .single_channel_q(sgl),
      .irq_events(ev), .legacy_irq_req(legacy), .irq_shared_q(irq_sh),
      .converter_ready(conv_rdy), .chip_power_down(pdn), .peak_valid(pk_v),
      .peak_left_in(pl), .peak_right_in(pr), .cap_in_valid(cv), .cap_in_data(cd),
      .cap_in_ready(cap_rdy), .pb_tick(tick), .pb_dac_q(dac), .pb_dac_valid_q(dac_v),
      .ind_commit_q(cm), .ind_commit_index_q(cm_i), .ind_commit_data_q(cm_d),
      .pb_setup_q(pbs), .cap_setup_q(cps), .game_raw_in(gr), .axis_count_in(axis));
   always @(posedge core_clk) begin
      if (cm) n_cm <= n_cm + 1;
      if (hit) n_hit <= n_hit + 1;
      if (dac_v) n_dac <= n_dac + 1;
      if (dac_v) last_dac <= dac;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic rchk(input logic [3:0] ofs, input logic [7:0] mask, input logic [7:0] exp);
      n_rd++;
      host_u.rd(ofs, rdata);
      chk($sformatf("offset %h", ofs), rdata & mask, exp);
   endtask
   task automatic pulse(ref logic s);
      @(negedge core_clk);
      s = 1'b1;
      @(negedge core_clk);
      s = 1'b0;
      repeat (2) @(negedge core_clk);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #50000;
      n_errors++;
      complete_run();
   end
   initial begin
      repeat (16) @(negedge core_clk);
      reset = 1'b0;
      // reset values and map
      rchk(4'h0, 8'hff, RST_STATUS_INDEX);
      rchk(4'h1, 8'hff, RST_IRQ_FLAGS);
      rchk(4'hd, 8'hff, RST_GAME_CTRL);
      for (int i = 7; i < 12; i++) if (i != 8 && i != 9) rchk(i[3:0], 8'hff, 8'h00);
      rchk(4'hc, 8'hff, 8'h5a);
      rchk(4'he, 8'hff, 8'hef);
      rchk(4'hf, 8'hff, 8'hbe);
      conv_rdy = 1'b1;
      rchk(4'h0, 8'h80, 8'h80);
      host_u.wr(4'h0, 8'hff);
      rchk(4'h0, 8'hbf, 8'hbf);
      $display("test map done");
      // indirect file, last and a low index
      host_u.idle = 2;
      for (int k = 0; k < 2; k++) begin
         host_u.wr(4'h0, k ? 8'h05 : 8'h23);
         host_u.wr(4'h2, 8'h34 + k[7:0]);
         host_u.wr(4'h3, 8'h12);
         repeat (2) @(negedge core_clk);
         chk("commit index", {26'h0, cm_i}, k ? 32'h5 : 32'h23);
         chk("commit data", {16'h0, cm_d}, 32'h1234 + k);
         chk("commit count", n_cm, k + 1);
      end
      host_u.idle = 0;
      // a lone low byte leaves the stored word untouched
      host_u.wr(4'h2, 8'h99);
      rchk(4'h2, 8'hff, 8'h35);
      rchk(4'h3, 8'hff, 8'h12);
      chk("no commit on low", n_cm, 2);
      host_u.wr(4'h3, 8'h56);
      chk("pair commit", {16'h0, cm_d}, 32'h5699);
      host_u.wr(4'h0, 8'h24);
      host_u.wr(4'h3, 8'h77);
      rchk(4'h2, 8'hff, 8'h00);
      chk("no commit past file", n_cm, 3);
      $display("test indirect done");
      // sticky flags
      ev = 8'h04;
      @(negedge core_clk);
      ev = 8'h00;
      rchk(4'h1, 8'hff, 8'h04);
      host_u.wr(4'h1, 8'h00);
      ev = 8'hff;
      @(negedge core_clk);
      ev = 8'h00;
      rchk(4'h1, 8'hff, 8'hff);
      chk("shared irq", irq_sh, 1);
      host_u.wr(4'h1, 8'hfe);
      rchk(4'h1, 8'hff, 8'hfe);
      // event in the clearing cycle wins
      fork
         host_u.wr(4'h1, 8'h00);
         begin
            @(negedge core_clk);
            ev = 8'h02;
            @(negedge core_clk);
            ev = 8'h00;
         end
      join
      rchk(4'h1, 8'hff, 8'h02);
      host_u.wr(4'h1, 8'h00);
      rchk(4'h1, 8'hff, 8'h00);
      chk("shared irq idle", irq_sh, 0);
      legacy = 1'b1;
      repeat (2) @(negedge core_clk);
      chk("shared irq legacy", irq_sh, 1);
      legacy = 1'b0;
      $display("test irq done");
      // peak codes
      pl = 2'h2;
      pr = 2'h1;
      pulse(pk_v);
      pl = 2'h1;
      pr = 2'h0;
      pulse(pk_v);
      rchk(4'h4, 8'h0f, 8'h06);
      host_u.wr(4'h4, 8'h00);
      rchk(4'h4, 8'h0f, 8'h00);
      pl = 2'h3;
      pr = 2'h3;
      pulse(pk_v);
      rchk(4'h4, 8'h0f, 8'h0f);
      pulse(pdn);
      rchk(4'h4, 8'h0f, 8'h00);
      $display("test peak done");
      // capture stream
      host_u.wr(4'h9, 8'h03);
      chk("capture setup", cps, 8'h03);
      for (int s = 0; s < 17; s++) begin
         cd = 32'h40302010 + s * 32'h01010101;
         pulse(cv);
         if (s == 0) rchk(4'h5, 8'h0f, 8'h06);
         if (s == 7) rchk(4'h5, 8'h08, 8'h08);
         if (s == 6) rchk(4'h5, 8'h08, 8'h00);
      end
      rchk(4'h4, 8'h10, 8'h10);
      chk("full refuses", cap_rdy, 0);
      for (int k = 0; k < 4; k++) begin
         rchk(4'h5, 8'h03, {6'h0, ~k[1], k[0]});
         rchk(4'h6, 8'hff, 8'h10 * (k + 1));
      end
      rchk(4'h4, 8'h10, 8'h00);
      $display("test capture done");
      // playback stream
      host_u.wr(4'h8, 8'h03);
      chk("playback setup", pbs, 8'h03);
      pulse(tick);
      chk("starved sample", last_dac, PB_MIDSCALE);
      rchk(4'h4, 8'h20, 8'h20);
      for (int k = 0; k < 4; k++) begin
         rchk(4'h5, 8'h70, {1'b0, 1'b1, ~k[1], k[0], 4'h0});
         host_u.wr(4'h6, 8'h11 * (k + 1));
      end
      rchk(4'h4, 8'h20, 8'h00);
      rchk(4'h5, 8'h40, 8'h00);
      pulse(tick);
      chk("played sample", last_dac, 32'h44332211);
      chk("ticks", n_dac, 2);
      $display("test playback done");
      // resource selections
      capd = 3'h3;
      foreach (irq_list[k]) begin
         irq_ch = irq_list[k];
         repeat (3) @(negedge core_clk);
         chk("irq ok", rok, 1);
      end
      chk("dual channel", sgl, 0);
      capd = DMA_SINGLE;
      irq_ch = 4'h6;
      repeat (3) @(negedge core_clk);
      chk("single channel", sgl, 1);
      chk("irq refused", rok, 0);
      irq_ch = 4'h7;
      pbd = 3'h2;
      repeat (3) @(negedge core_clk);
      chk("dma refused", rok, 0);
      pbd = 3'h0;
      codec_io_base = 10'h208;
      repeat (3) @(negedge core_clk);
      chk("base refused", rok, 0);
      codec_io_base = 10'h3f0;
      repeat (3) @(negedge core_clk);
      chk("base ok", rok, 1);
      // window moved away, this read must miss
      host_u.rd(4'h0, rdata);
      chk("hit count", n_hit, n_rd);
      $display("test resources done");
      complete_run();
   end
endmodule // testbench
`default_nettype wire

// File: logic/shd_direct_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - sixteen direct bytes, thirty-six indirect words
// - index bits 5..0 pick indirect word
// - high data byte write commits the word
// - codec and legacy share one irq
// - capture dma four means single channel
// - two-bit peak code per adc channel
// - peak held until debug write or powerdown
// - capture overrun when full, samples dropped
// - overrun cleared after four-byte sample read
// - playback underrun when starved one period
// - underrun cleared by full sample, midscale out
// - capture next byte upper or lower
// - capture data left or right channel
// - capture avail with four bytes, pio mode
// - capture level flag at thirty-two bytes
// - playback next byte upper or lower
module shd_direct_regs
   import shd_pkg::*;
#(
   parameter int FIFO_DEPTH = CAP_DEPTH
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // host register port
   input wire logic [9:0] host_addr,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [7:0] host_wdata,
   output logic [7:0] host_rdata_q,
   output logic host_hit_q,
   // resource configuration
   input wire logic [9:0] codec_io_base,
   input wire logic [3:0] irq_channel,
   input wire logic [2:0] pb_dma_sel,
   input wire logic [2:0] cap_dma_sel,
   output logic resource_ok_q,
   output logic single_channel_q,
   // interrupt events
   input wire logic [7:0] irq_events,
   input wire logic legacy_irq_req,
   output logic irq_shared_q,
   // core status
   input wire logic converter_ready,
   input wire logic chip_power_down,
   // peak detect
   input wire logic peak_valid,
   input wire logic [1:0] peak_left_in,
   input wire logic [1:0] peak_right_in,
   // capture stream
   input wire logic cap_in_valid,
   input wire logic [31:0] cap_in_data,
   output logic cap_in_ready,
   // playback stream
   input wire logic pb_tick,
   output logic [31:0] pb_dac_q,
   output logic pb_dac_valid_q,
   // indirect commit
   output logic ind_commit_q,
   output logic [5:0] ind_commit_index_q,
   output logic [15:0] ind_commit_data_q,
   // setup registers
   output logic [7:0] pb_setup_q,
   output logic [7:0] cap_setup_q,
   // game port
   input wire logic [7:0] game_raw_in,
   input wire logic [15:0] axis_count_in
);
   localparam int CW = $clog2(FIFO_DEPTH + 1);

   function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] i);
      byte_of = w[8 * i +: 8];
   endfunction

   function automatic logic dma_legal(input logic [2:0] ch);
      dma_legal = (ch == 3'h0) || (ch == 3'h1) || (ch == 3'h3);
   endfunction

   function automatic logic [1:0] peak_max(input logic [1:0] a, input logic [1:0] b);
      peak_max = (a > b) ? a : b;
   endfunction

   logic [15:0] ind_mem [IND_COUNT];
   logic [7:0] status_index_q;
   logic [7:0] irq_flags_q;
   logic [7:0] data_low_q;
   logic [7:0] game_ctrl_q;
   logic [1:0] peak_left_q;
   logic [1:0] peak_right_q;
   logic overrun_q;
   logic underrun_q;
   logic ready_q;
   logic [1:0] cap_byte_q;
   logic [1:0] pb_byte_q;
   logic [31:0] pb_asm_q;
   logic [31:0] pb_word_q;
   logic pb_full_q;
   logic [7:0] rdata_d;
   logic hit;
   logic [3:0] ofs;
   logic wr_hit;
   logic rd_hit;
   logic [5:0] index;
   logic index_ok;
   logic cap_run;
   logic cap_pio;
   logic pb_run;
   logic fifo_in_ready;
   logic cap_valid;
   logic cap_pop;
   logic [31:0] cap_head;
   logic [CW-1:0] cap_count;
   logic cap_avail;
   logic cap_level;
   logic cap_drop;
   logic cap_last_read;
   logic pb_take;
   logic pb_last_write;
   logic pb_starve;
   logic [7:0] xfer_status;

   assign hit = (host_addr[9:4] == codec_io_base[9:4]);
   assign ofs = host_addr[3:0];
   assign wr_hit = host_wr && hit;
   assign rd_hit = host_rd && hit;
   assign index = status_index_q[5:0];
   assign index_ok = (index <= IND_LAST);
   assign cap_run = cap_setup_q[BIT_CEN];
   assign cap_pio = cap_setup_q[BIT_CIO];
   assign pb_run = pb_setup_q[BIT_PEN] && pb_setup_q[BIT_PIO];
   assign cap_avail = cap_pio && (cap_count >= CW'(CAP_AVAIL_WORDS));
   assign cap_level = (cap_count >= CW'(CAP_LEVEL_WORDS));
   assign cap_drop = cap_in_valid && cap_run && !fifo_in_ready;
   assign cap_last_read = rd_hit && (ofs == OFS_SAMPLE_PORT) && cap_valid
      && (cap_byte_q == LAST_BYTE);
   assign cap_pop = cap_last_read;
   assign pb_take = wr_hit && (ofs == OFS_SAMPLE_PORT) && pb_run && !pb_full_q;
   assign pb_last_write = pb_take && (pb_byte_q == LAST_BYTE);
   assign pb_starve = pb_tick && pb_run && !pb_full_q;
   assign cap_in_ready = fifo_in_ready;

   // bytes 0,1 are the left channel, byte 0 of each channel is the lower half
   assign xfer_status = {1'b0, !pb_full_q, !pb_byte_q[1], pb_byte_q[0],
                         cap_level, cap_avail, !cap_byte_q[1], cap_byte_q[0]};

   shd_fifo #(
      .WIDTH(32),
      .DEPTH(FIFO_DEPTH),
      .CW(CW)
   ) u_cap_fifo (
      .core_clk(core_clk),
      .reset(reset),
      .in_valid(cap_in_valid && cap_run),
      .in_ready(fifo_in_ready),
      .in_data(cap_in_data),
      .out_valid(cap_valid),
      .out_ready(cap_pop),
      .out_data(cap_head),
      .count(cap_count)
   );

   // read mux
   always_comb begin
      rdata_d = 8'h00;
      unique case (ofs)
         OFS_STATUS_INDEX: rdata_d = {ready_q, status_index_q[BIT_VBL], index};
         OFS_IRQ_FLAGS: rdata_d = irq_flags_q;
         OFS_DATA_LOW: rdata_d = index_ok ? ind_mem[index][7:0] : 8'h00;
         OFS_DATA_HIGH: rdata_d = index_ok ? ind_mem[index][15:8] : 8'h00;
         OFS_OVERRANGE: rdata_d = {2'h0, underrun_q, overrun_q, peak_right_q, peak_left_q};
         OFS_XFER_STATUS: rdata_d = xfer_status;
         OFS_SAMPLE_PORT: rdata_d = cap_valid ? byte_of(cap_head, cap_byte_q) : 8'h00;
         OFS_PB_SETUP: rdata_d = pb_setup_q;
         OFS_CAP_SETUP: rdata_d = cap_setup_q;
         OFS_GAME_RAW: rdata_d = game_raw_in;
         OFS_GAME_CTRL: rdata_d = game_ctrl_q;
         OFS_AXIS_LOW: rdata_d = axis_count_in[7:0];
         OFS_AXIS_HIGH: rdata_d = axis_count_in[15:8];
         OFS_RSVD_SEVEN, OFS_RSVD_TEN, OFS_RSVD_ELEVEN: rdata_d = 8'h00;
      endcase
   end

   // read answer
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         host_rdata_q <= 8'h00;
         host_hit_q <= 1'b0;
      end else begin
         host_hit_q <= rd_hit;
         if (rd_hit) begin
            host_rdata_q <= rdata_d;
         end
      end
   end

   // index, setup and game control
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         status_index_q <= RST_STATUS_INDEX;
         data_low_q <= 8'h00;
         pb_setup_q <= RST_SETUP;
         cap_setup_q <= RST_SETUP;
         game_ctrl_q <= RST_GAME_CTRL;
         ready_q <= 1'b0;
      end else begin
         ready_q <= converter_ready;
         if (wr_hit && (ofs == OFS_STATUS_INDEX)) begin
            status_index_q <= {1'b0, host_wdata[6:0]};
         end
         if (wr_hit && (ofs == OFS_DATA_LOW)) begin
            data_low_q <= host_wdata;
         end
         if (wr_hit && (ofs == OFS_PB_SETUP)) begin
            pb_setup_q <= host_wdata;
         end
         if (wr_hit && (ofs == OFS_CAP_SETUP)) begin
            cap_setup_q <= host_wdata;
         end
         if (wr_hit && (ofs == OFS_GAME_CTRL)) begin
            game_ctrl_q <= {game_ctrl_q[7], host_wdata[6:0]};
         end
      end
   end

   // indirect file, committed on the high byte
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < IND_COUNT; i++) begin
            ind_mem[i] <= RST_IND_WORD;
         end
         ind_commit_q <= 1'b0;
         ind_commit_index_q <= 6'h00;
         ind_commit_data_q <= 16'h0000;
      end else begin
         ind_commit_q <= 1'b0;
         if (wr_hit && (ofs == OFS_DATA_HIGH) && index_ok) begin
            ind_mem[index] <= {host_wdata, data_low_q};
            ind_commit_q <= 1'b1;
            ind_commit_index_q <= index;
            ind_commit_data_q <= {host_wdata, data_low_q};
         end
      end
   end

   // sticky interrupt flags, set wins over a zero write
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         irq_flags_q <= RST_IRQ_FLAGS;
         irq_shared_q <= 1'b0;
      end else begin
         if (wr_hit && (ofs == OFS_IRQ_FLAGS)) begin
            irq_flags_q <= (irq_flags_q & host_wdata) | irq_events;
         end else begin
            irq_flags_q <= irq_flags_q | irq_events;
         end
         irq_shared_q <= (|irq_flags_q) || legacy_irq_req;
      end
   end

   // resource checks
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         resource_ok_q <= 1'b0;
         single_channel_q <= 1'b1;
      end else begin
         single_channel_q <= (cap_dma_sel == DMA_SINGLE);
         resource_ok_q <= (codec_io_base >= BASE_MIN) && (codec_io_base <= BASE_MAX)
            && (codec_io_base[3:0] == 4'h0)
            && ((irq_channel == 4'h5) || (irq_channel == 4'h7) || (irq_channel == 4'h9)
            || (irq_channel == 4'hb) || (irq_channel == 4'hc) || (irq_channel == 4'hf))
            && dma_legal(pb_dma_sel)
            && (dma_legal(cap_dma_sel) || (cap_dma_sel == DMA_SINGLE));
      end
   end

   // peak codes, new peaks win over a clearing write
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         peak_left_q <= PEAK_NONE;
         peak_right_q <= PEAK_NONE;
      end else begin
         if (chip_power_down || (wr_hit && (ofs == OFS_OVERRANGE))) begin
            peak_left_q <= peak_valid ? peak_left_in : PEAK_NONE;
            peak_right_q <= peak_valid ? peak_right_in : PEAK_NONE;
         end else if (peak_valid) begin
            peak_left_q <= peak_max(peak_left_q, peak_left_in);
            peak_right_q <= peak_max(peak_right_q, peak_right_in);
         end
      end
   end

   // capture byte walk and overrun
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cap_byte_q <= 2'h0;
         overrun_q <= 1'b0;
      end else begin
         if (rd_hit && (ofs == OFS_SAMPLE_PORT) && cap_valid) begin
            cap_byte_q <= cap_byte_q + 2'h1;
         end
         if (cap_drop) begin
            overrun_q <= 1'b1;
         end else if (cap_last_read) begin
            overrun_q <= 1'b0;
         end
      end
   end

   // playback assembly, hand-off and underrun
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pb_byte_q <= 2'h0;
         pb_asm_q <= 32'h0000_0000;
         pb_word_q <= 32'h0000_0000;
         pb_full_q <= 1'b0;
         underrun_q <= 1'b0;
         pb_dac_q <= PB_MIDSCALE;
         pb_dac_valid_q <= 1'b0;
      end else begin
         pb_dac_valid_q <= pb_tick && pb_run;
         if (pb_take) begin
            pb_byte_q <= pb_byte_q + 2'h1;
            pb_asm_q[8 * pb_byte_q +: 8] <= host_wdata;
         end
         if (pb_last_write) begin
            pb_word_q <= {host_wdata, pb_asm_q[23:0]};
            pb_full_q <= 1'b1;
         end else if (pb_tick && pb_run && pb_full_q) begin
            pb_full_q <= 1'b0;
         end
         if (pb_tick && pb_run) begin
            pb_dac_q <= pb_full_q ? pb_word_q : PB_MIDSCALE;
         end
         if (pb_starve) begin
            underrun_q <= 1'b1;
         end else if (pb_last_write) begin
            underrun_q <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   sequence s_high_write;
      wr_hit && (ofs == OFS_DATA_HIGH) && index_ok;
   endsequence

   sequence s_commit_seen;
      ind_commit_q && (ind_commit_index_q == $past(index));
   endsequence

   a_high_commits: assert property (s_high_write |=> s_commit_seen)
      else $error("high byte write did not commit");
   a_low_no_commit: assert property (wr_hit && (ofs == OFS_DATA_LOW) |=> !ind_commit_q)
      else $error("low byte write committed");
   a_commit_word: assert property (ind_commit_q |-> ind_mem[ind_commit_index_q]
      == ind_commit_data_q)
      else $error("indirect word not stored");
   a_peak_clear: assert property (wr_hit && (ofs == OFS_OVERRANGE) && !peak_valid
      |=> (peak_left_q == PEAK_NONE) && (peak_right_q == PEAK_NONE))
      else $error("peak codes not cleared");
   a_peak_hold: assert property (!(wr_hit && (ofs == OFS_OVERRANGE)) && !chip_power_down
      |=> peak_left_q >= $past(peak_left_q))
      else $error("peak code dropped");
   a_overrun_set: assert property (cap_drop |=> overrun_q)
      else $error("overrun not flagged");
   a_overrun_clear: assert property (cap_last_read && !cap_drop |=> !overrun_q)
      else $error("overrun not cleared");
   a_underrun_set: assert property (pb_starve |=> underrun_q ##0 (pb_dac_q == PB_MIDSCALE))
      else $error("underrun not flagged");
   a_underrun_clear: assert property (pb_last_write && !pb_starve |=> !underrun_q)
      else $error("underrun not cleared");
   a_irq_sticky: assert property (irq_flags_q[0] && !(wr_hit && (ofs == OFS_IRQ_FLAGS))
      |=> irq_flags_q[0] ##1 irq_shared_q)
      else $error("sticky flag lost");
   a_single_mode: assert property ((cap_dma_sel == DMA_SINGLE) [*2] |-> single_channel_q)
      else $error("single channel mode missing");
   a_avail_flag: assert property (cap_avail |-> cap_pio && cap_valid)
      else $error("capture avail without data");
endmodule // shd_direct_regs
`default_nettype wire

// File: logic/shd_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module shd_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16,
   parameter int CW = $clog2(DEPTH + 1)
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [CW-1:0] count
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [CW-1:0] count_q;
   logic [CW-1:0] count_d;
   logic in_ready_q;
   logic push;
   logic pop;

   assign push = in_valid && in_ready_q;
   assign pop = out_ready && (count_q != '0);
   assign in_ready = in_ready_q;
   assign out_valid = (count_q != '0);
   assign out_data = mem[rd_ptr_q];
   assign count = count_q;

   always_comb begin
      count_d = count_q;
      if (push && !pop) begin
         count_d = count_q + 1'b1;
      end else if (pop && !push) begin
         count_d = count_q - 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_ptr_q] <= in_data;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
         in_ready_q <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         end
         count_q <= count_d;
         in_ready_q <= (count_d != CW'(DEPTH));
      end
   end
endmodule // shd_fifo
`default_nettype wire

// File: logic/shd_pkg.sv
`default_nettype none
package shd_pkg;
   // direct register offsets
   localparam logic [3:0] OFS_STATUS_INDEX = 4'h0;
   localparam logic [3:0] OFS_IRQ_FLAGS = 4'h1;
   localparam logic [3:0] OFS_DATA_LOW = 4'h2;
   localparam logic [3:0] OFS_DATA_HIGH = 4'h3;
   localparam logic [3:0] OFS_OVERRANGE = 4'h4;
   localparam logic [3:0] OFS_XFER_STATUS = 4'h5;
   localparam logic [3:0] OFS_SAMPLE_PORT = 4'h6;
   localparam logic [3:0] OFS_RSVD_SEVEN = 4'h7;
   localparam logic [3:0] OFS_PB_SETUP = 4'h8;
   localparam logic [3:0] OFS_CAP_SETUP = 4'h9;
   localparam logic [3:0] OFS_RSVD_TEN = 4'ha;
   localparam logic [3:0] OFS_RSVD_ELEVEN = 4'hb;
   localparam logic [3:0] OFS_GAME_RAW = 4'hc;
   localparam logic [3:0] OFS_GAME_CTRL = 4'hd;
   localparam logic [3:0] OFS_AXIS_LOW = 4'he;
   localparam logic [3:0] OFS_AXIS_HIGH = 4'hf;
   // window and indirect file
   localparam int DIRECT_COUNT = 16;
   localparam int IND_COUNT = 36;
   localparam logic [5:0] IND_LAST = 6'h23;
   localparam logic [9:0] BASE_MIN = 10'h100;
   localparam logic [9:0] BASE_MAX = 10'h3f8;
   // field positions
   localparam int BIT_READY = 7;
   localparam int BIT_VBL = 6;
   localparam int BIT_PEN = 0;
   localparam int BIT_PIO = 1;
   localparam int BIT_CEN = 0;
   localparam int BIT_CIO = 1;
   // reset values
   localparam logic [7:0] RST_STATUS_INDEX = 8'h00;
   localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
   localparam logic [7:0] RST_SETUP = 8'h00;
   localparam logic [7:0] RST_GAME_CTRL = 8'hf0;
   localparam logic [15:0] RST_IND_WORD = 16'h0000;
   localparam logic [1:0] PEAK_NONE = 2'h0;
   // sample stream
   localparam int SAMPLE_BYTES = 4;
   localparam logic [1:0] LAST_BYTE = 2'h3;
   localparam int CAP_DEPTH = 16;
   localparam int CAP_AVAIL_WORDS = 1;
   localparam int CAP_LEVEL_WORDS = 8;
   localparam logic [31:0] PB_MIDSCALE = 32'h0000_0000;
   // resource selections
   localparam logic [2:0] DMA_SINGLE = 3'h4;
endpackage
`default_nettype wire
